//--- shared/aipc_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef AIPC_PARAMS_SVH
`define AIPC_PARAMS_SVH
`define AIPC_OFF_MODE     12'h000
`define AIPC_OFF_KFACTOR  12'h004
`define AIPC_OFF_VPI      12'h008
`define AIPC_OFF_INJVOL   12'h00C
`define AIPC_OFF_SELFPER  12'h010
`define AIPC_OFF_MINTX    12'h014
`define AIPC_OFF_ENDTIME  12'h018
`define AIPC_OFF_LOWRATE  12'h01C
`define AIPC_OFF_CMD      12'h020
`define AIPC_OFF_STATUS   12'h024
`define AIPC_OFF_WILDVOL  12'h028
`define AIPC_OFF_INJCNT   12'h02C
`define AIPC_CMD_INJNOW   0
`define AIPC_CMD_OPEN     1
`define AIPC_CMD_CLOSE    2
`define AIPC_CMD_PERM_EN  3
`define AIPC_CMD_PERM_DIS 4
`define AIPC_RST_KFACTOR  32'h0000_0001
`define AIPC_RST_VPI      32'h0000_0050
`define AIPC_RST_INJVOL   32'h0000_000A
`define AIPC_RST_SELFPER  32'h0000_2710
`define AIPC_RST_MINTX    32'h0000_0001
`define AIPC_RST_ENDTIME  32'h0000_2710
`define AIPC_RST_LOWRATE  32'h0000_0001
`define AIPC_RATE_WINDOW  32'h0000_2710
`endif

//--- shared/aipc_pkg.sv
// Types for the additive injection pacing control block
package aipc_pkg;
    typedef enum logic [1:0] {
        AM_SMART = 2'b00,
        AM_SLAVE = 2'b01,
        AM_SELF  = 2'b10
    } aipc_addmode_t;
    typedef enum logic [1:0] {
        SRC_NONE   = 2'b00,
        SRC_PULSE  = 2'b01,
        SRC_ANALOG = 2'b10,
        SRC_DIGITAL_SERIAL = 2'b11
    } aipc_src_t;
    typedef enum logic [2:0] {
        OM_SMART_PULSE   = 3'b000,
        OM_SMART_ANALOG  = 3'b001,
        OM_SMART_INJECT  = 3'b010,
        OM_SMART_SERIAL  = 3'b011,
        OM_SLAVE_INJECT  = 3'b100,
        OM_SLAVE_SERIAL  = 3'b101,
        OM_SELF          = 3'b110,
        OM_IDLE          = 3'b111
    } aipc_opmode_t;
    // Pacing/solenoid source: 0 none, 1 pulse, 2 analog, 3 digital, 4 serial
    typedef struct packed {
        logic [1:0] add_mode;
        logic [2:0] pace_src;
        logic [2:0] sol_src;
        logic [1:0] perm_src;
        logic       ilk_bound;
        logic       ilk_and;
    } aipc_cfg_t;
endpackage : aipc_pkg

//--- verilog/aipc_core.sv
// Additive injection mode, pacing and permissive logic with AHB-Lite regs
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "aipc_params.svh"
module aipc_core (
    input  wire logic        CLOCK_IN,
    input  wire logic        RESETN_IN,
    input  wire logic        HSEL_IN,
    input  wire logic [31:0] HADDR_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [2:0]  HSIZE_IN,
    input  wire logic [31:0] HWDATA_IN,
    input  wire logic        HREADY_IN,
    output logic      [31:0] HRDATA_OUT,
    output logic             HREADYOUT_OUT,
    output logic             HRESP_OUT,
    input  wire logic        PULSE_INPUT_SOURCE_IN,
    input  wire logic        PULSE_INPUT_SOURCE_B_IN,
    input  wire logic        ANALOG_INPUT_SOURCE_IN,
    input  wire logic        DIGITAL_INPUT_SOURCE_IN,
    input  wire logic        PERMISSIVE_IN,
    input  wire logic        INTERLOCK_IN,
    output logic             SOLENOID_OUT,
    output logic             TRANSACTION_OUT,
    output logic             PERMISSIVE_OUT,
    output logic      [1:0]  PULSE_INPUTS_USED_OUT
);
    // Plain-number settings; reset defaults sit in the params header
    logic [31:0]        kfactor_reg;    // Pulses per volume unit
    logic [31:0]        vpi_reg;        // Volume between injections
    logic [31:0]        injvol_reg;     // Volume dispensed per injection
    logic [31:0]        selfper_reg;    // Self-pace period, cycles
    logic [31:0]        mintx_reg;      // Minimum transaction volume
    logic [31:0]        endtime_reg;    // End-transaction time, cycles
    logic [31:0]        lowrate_reg;    // Low-flow volume per window
    aipc_pkg::aipc_cfg_t cfg_reg;       // Mode and binding selection
    logic [31:0]        wild_reg;       // Wild-stream accumulator
    logic [31:0]        total_reg;      // Total flowed, for start check
    logic [31:0]        injcnt_reg;     // Injections started
    logic [31:0]        pcnt_reg;       // Pulses toward one volume unit
    logic [31:0]        dose_reg;       // Remaining dose of current cycle
    logic               sol_latch_reg;  // Slave command latch
    logic               ser_perm_reg;   // Serial permissive latch
    logic               tx_reg;         // Transaction active
    logic [31:0]        self_tmr_reg;   // Self-pace timer
    logic [31:0]        idle_tmr_reg;   // Time since last activity
    logic [31:0]        win_tmr_reg;    // Flow-rate window timer
    logic [31:0]        win_vol_reg;    // Volume in current window
    logic [31:0]        low_tmr_reg;    // Time spent below low rate
    logic               low_flow_reg;   // Last window below low rate
    aipc_pkg::aipc_opmode_t mode;       // Decoded operating mode

    // Two-stage synchronisers for the external pins
    logic [5:0] s1_reg;
    logic [5:0] s2_reg;
    logic [5:0] s3_reg;                 // Previous value for edges
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            s1_reg <= 6'h00;
            s2_reg <= 6'h00;
            s3_reg <= 6'h00;
        end else begin
            s1_reg <= {INTERLOCK_IN, PERMISSIVE_IN, PULSE_INPUT_SOURCE_B_IN,
                       DIGITAL_INPUT_SOURCE_IN, ANALOG_INPUT_SOURCE_IN,
                       PULSE_INPUT_SOURCE_IN};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    logic pi_rise;
    logic ai_rise;
    logic di_rise;
    assign pi_rise = s2_reg[0] & ~s3_reg[0];
    assign ai_rise = s2_reg[1] & ~s3_reg[1];
    assign di_rise = s2_reg[2] & ~s3_reg[2];

    // Mode decode from three settings
    always_comb begin
        unique case (cfg_reg.add_mode)
            aipc_pkg::AM_SMART: begin
                // Pacing source picks the smart variant
                case (cfg_reg.pace_src)
                    3'h1:    mode = aipc_pkg::OM_SMART_PULSE;
                    3'h2:    mode = aipc_pkg::OM_SMART_ANALOG;
                    3'h3:    mode = aipc_pkg::OM_SMART_INJECT;
                    3'h4:    mode = aipc_pkg::OM_SMART_SERIAL;
                    default: mode = aipc_pkg::OM_IDLE;
                endcase
            end
            aipc_pkg::AM_SLAVE: begin
                // Pacing source ignored, solenoid binding decides
                case (cfg_reg.sol_src)
                    3'h2, 3'h3: mode = aipc_pkg::OM_SLAVE_INJECT;
                    3'h4:       mode = aipc_pkg::OM_SLAVE_SERIAL;
                    default:    mode = aipc_pkg::OM_IDLE;
                endcase
            end
            aipc_pkg::AM_SELF: mode = aipc_pkg::OM_SELF;
            default:           mode = aipc_pkg::OM_IDLE;
        endcase
    end

    // Stream consumes two pulse inputs only in smart pulse mode
    always_comb begin
        PULSE_INPUTS_USED_OUT = (mode == aipc_pkg::OM_SMART_PULSE) ?
                                2'h2 : 2'h1;
    end

    // AHB-Lite slave: latch address phase, act in data phase
    logic        dp_valid_reg;
    logic        dp_write_reg;
    logic [11:0] dp_addr_reg;
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg  <= 12'h000;
        end else if (HREADY_IN) begin
            dp_valid_reg <= HSEL_IN & HTRANS_IN[1];
            dp_write_reg <= HWRITE_IN;
            dp_addr_reg  <= HADDR_IN[11:0];
        end
    end
    assign HREADYOUT_OUT = 1'b1;   // Zero wait states
    assign HRESP_OUT     = 1'b0;   // Always OKAY
    logic wr;
    assign wr = dp_valid_reg & dp_write_reg;
    logic [4:0] cmd;               // Command pulses this cycle
    assign cmd = (wr && dp_addr_reg == `AIPC_OFF_CMD) ? HWDATA_IN[4:0]
                                                      : 5'h00;

    // Configuration writes
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            cfg_reg     <= '0;
            kfactor_reg <= `AIPC_RST_KFACTOR;
            vpi_reg     <= `AIPC_RST_VPI;
            injvol_reg  <= `AIPC_RST_INJVOL;
            selfper_reg <= `AIPC_RST_SELFPER;
            mintx_reg   <= `AIPC_RST_MINTX;
            endtime_reg <= `AIPC_RST_ENDTIME;
            lowrate_reg <= `AIPC_RST_LOWRATE;
        end else if (wr) begin
            case (dp_addr_reg)
                `AIPC_OFF_MODE:    cfg_reg     <= HWDATA_IN[11:0];
                `AIPC_OFF_KFACTOR: kfactor_reg <= HWDATA_IN;
                `AIPC_OFF_VPI:     vpi_reg     <= HWDATA_IN;
                `AIPC_OFF_INJVOL:  injvol_reg  <= HWDATA_IN;
                `AIPC_OFF_SELFPER: selfper_reg <= HWDATA_IN;
                `AIPC_OFF_MINTX:   mintx_reg   <= HWDATA_IN;
                `AIPC_OFF_ENDTIME: endtime_reg <= HWDATA_IN;
                `AIPC_OFF_LOWRATE: lowrate_reg <= HWDATA_IN;
                default: ;
            endcase
        end
    end

    // Read data registered at the address phase for stable data phase
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            HRDATA_OUT <= 32'h0000_0000;
        end else if (HREADY_IN && HSEL_IN && HTRANS_IN[1] && !HWRITE_IN) begin
            case (HADDR_IN[11:0])
                `AIPC_OFF_MODE:    HRDATA_OUT <= {20'h0, cfg_reg};
                `AIPC_OFF_KFACTOR: HRDATA_OUT <= kfactor_reg;
                `AIPC_OFF_VPI:     HRDATA_OUT <= vpi_reg;
                `AIPC_OFF_INJVOL:  HRDATA_OUT <= injvol_reg;
                `AIPC_OFF_SELFPER: HRDATA_OUT <= selfper_reg;
                `AIPC_OFF_MINTX:   HRDATA_OUT <= mintx_reg;
                `AIPC_OFF_ENDTIME: HRDATA_OUT <= endtime_reg;
                `AIPC_OFF_LOWRATE: HRDATA_OUT <= lowrate_reg;
                `AIPC_OFF_STATUS:  HRDATA_OUT <= {22'h0, mode, low_flow_reg,
                    ser_perm_reg, sol_latch_reg, PERMISSIVE_OUT,
                    tx_reg, SOLENOID_OUT, (dose_reg != 32'h0)};
                `AIPC_OFF_WILDVOL: HRDATA_OUT <= wild_reg;
                `AIPC_OFF_INJCNT:  HRDATA_OUT <= injcnt_reg;
                default:           HRDATA_OUT <= 32'h0000_0000;
            endcase
        end
    end

    // Pulse to volume division: one unit per kfactor pulses
    logic unit_tick;
    assign unit_tick = (mode == aipc_pkg::OM_SMART_PULSE) && pi_rise &&
                       (pcnt_reg + 32'h1 >= kfactor_reg);
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pcnt_reg <= 32'h0;
        end else if (mode != aipc_pkg::OM_SMART_PULSE) begin
            pcnt_reg <= 32'h0;
        end else if (pi_rise) begin
            pcnt_reg <= unit_tick ? 32'h0 : pcnt_reg + 32'h1;
        end
    end

    // Analog flow level treated as volume-unit pulses in smart analog
    logic vol_add;                 // Volume increment this cycle
    logic [31:0] add_amt;
    always_comb begin
        vol_add = 1'b0;
        add_amt = 32'h0;
        if (unit_tick) begin
            vol_add = 1'b1;
            add_amt = 32'h1;
        end else if (mode == aipc_pkg::OM_SMART_ANALOG && ai_rise) begin
            vol_add = 1'b1;
            add_amt = 32'h1;
        end else if (mode == aipc_pkg::OM_SMART_INJECT && di_rise) begin
            // Trigger only credits the threshold volume
            vol_add = 1'b1;
            add_amt = vpi_reg;
        end
    end

    // Injection triggers for every pacing style
    logic vol_trig;
    logic edge_trig;
    logic ser_trig;
    logic self_trig;
    logic inject;
    assign vol_trig  = (mode == aipc_pkg::OM_SMART_PULSE ||
                        mode == aipc_pkg::OM_SMART_ANALOG) &&
                       (wild_reg >= vpi_reg) && (vpi_reg != 32'h0);
    // Rising edge of digital inject-now input (pace_src is always 3 in this mode)
    assign edge_trig = (mode == aipc_pkg::OM_SMART_INJECT) &&
                       ((cfg_reg.pace_src == 3'h3) ? di_rise : ai_rise);
    assign ser_trig  = (mode == aipc_pkg::OM_SMART_SERIAL) &&
                       cmd[`AIPC_CMD_INJNOW];
    assign self_trig = (mode == aipc_pkg::OM_SELF) &&
                       (self_tmr_reg + 32'h1 >= selfper_reg);
    assign inject    = vol_trig | edge_trig | ser_trig | self_trig;

    // Wild-stream accumulator with remainder kept
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            wild_reg  <= 32'h0;
            total_reg <= 32'h0;
        end else begin
            if (vol_trig) begin
                wild_reg <= wild_reg - vpi_reg + add_amt;
            end else if (vol_add) begin
                wild_reg <= wild_reg + add_amt;
            end
            if (tx_reg) begin
                total_reg <= 32'h0;  // Fresh count for next start
            end else if (vol_add) begin
                total_reg <= total_reg + add_amt;
            end
        end
    end

    // Self-pace repeating timer
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            self_tmr_reg <= 32'h0;
        end else if (mode != aipc_pkg::OM_SELF || self_trig) begin
            self_tmr_reg <= 32'h0;
        end else begin
            self_tmr_reg <= self_tmr_reg + 32'h1;
        end
    end

    // Dose counter: one cycle per volume unit; a new trigger restarts it
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            dose_reg   <= 32'h0;
            injcnt_reg <= 32'h0;
        end else if (inject) begin
            dose_reg   <= injvol_reg;
            injcnt_reg <= injcnt_reg + 32'h1;
        end else if (dose_reg != 32'h0) begin
            dose_reg <= dose_reg - 32'h1;
        end
    end

    // Slave command latch from serial commands
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            sol_latch_reg <= 1'b0;
        end else if (cmd[`AIPC_CMD_OPEN]) begin
            sol_latch_reg <= 1'b1;   // Open wins a same-cycle close
        end else if (cmd[`AIPC_CMD_CLOSE]) begin
            sol_latch_reg <= 1'b0;
        end
    end

    // Slave open condition; pin slave follows its input level
    logic slave_open;
    always_comb begin
        slave_open = 1'b0;
        if (mode == aipc_pkg::OM_SLAVE_SERIAL) begin
            slave_open = sol_latch_reg;
        end else if (mode == aipc_pkg::OM_SLAVE_INJECT) begin
            slave_open = (cfg_reg.sol_src == 3'h3) ? s2_reg[2]
                                                   : s2_reg[1];
        end
    end

    // Solenoid output, registered
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            SOLENOID_OUT <= 1'b0;
        end else if (mode == aipc_pkg::OM_SLAVE_SERIAL ||
                     mode == aipc_pkg::OM_SLAVE_INJECT) begin
            SOLENOID_OUT <= slave_open;
        end else begin
            // Only dose while the transaction is enabled
            SOLENOID_OUT <= PERMISSIVE_OUT && (inject || dose_reg > 32'h1);
        end
    end

    // Flow-rate window: low flow when window volume below threshold
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            win_tmr_reg  <= 32'h0;
            win_vol_reg  <= 32'h0;
            low_flow_reg <= 1'b1;
        end else if (win_tmr_reg + 32'h1 >= `AIPC_RATE_WINDOW) begin
            win_tmr_reg  <= 32'h0;
            win_vol_reg  <= 32'h0;
            low_flow_reg <= (win_vol_reg + (vol_add ? add_amt : 32'h0))
                            < lowrate_reg;
        end else begin
            win_tmr_reg <= win_tmr_reg + 32'h1;
            if (vol_add) begin
                win_vol_reg <= win_vol_reg + add_amt;
            end
        end
    end

    // Activity seen this cycle for the internal permissive
    logic active;
    always_comb begin
        unique case (mode)
            aipc_pkg::OM_SMART_INJECT,
            aipc_pkg::OM_SMART_SERIAL: active = edge_trig | ser_trig;
            aipc_pkg::OM_SLAVE_INJECT,
            aipc_pkg::OM_SLAVE_SERIAL: active = slave_open;
            default:                   active = ~low_flow_reg;
        endcase
    end

    // Idle timers for end-of-transaction
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            idle_tmr_reg <= 32'h0;
            low_tmr_reg  <= 32'h0;
        end else begin
            idle_tmr_reg <= active ? 32'h0 : idle_tmr_reg + 32'h1;
            low_tmr_reg  <= low_flow_reg ? low_tmr_reg + 32'h1 : 32'h0;
        end
    end

    // Internal transaction state for permissive source none
    logic vol_mode;
    assign vol_mode = mode == aipc_pkg::OM_SMART_PULSE ||
                      mode == aipc_pkg::OM_SMART_ANALOG;
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            tx_reg <= 1'b0;
        end else if (mode == aipc_pkg::OM_SELF ||
                     mode == aipc_pkg::OM_IDLE) begin
            tx_reg <= 1'b0;
        end else if (vol_mode) begin
            if (!tx_reg && total_reg > mintx_reg) begin
                tx_reg <= 1'b1;
            end else if (tx_reg && low_tmr_reg >= endtime_reg) begin
                tx_reg <= 1'b0;
            end
        end else if (active) begin
            tx_reg <= 1'b1;
        end else if (idle_tmr_reg >= endtime_reg) begin
            tx_reg <= 1'b0;
        end
    end

    // Serial permissive latch
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ser_perm_reg <= 1'b0;
        end else if (cmd[`AIPC_CMD_PERM_EN]) begin
            ser_perm_reg <= 1'b1;
        end else if (cmd[`AIPC_CMD_PERM_DIS]) begin
            ser_perm_reg <= 1'b0;
        end
    end

    // Primary permissive by binding, then interlock combine
    logic prim;
    always_comb begin
        unique case (cfg_reg.perm_src)
            2'h1:    prim = ser_perm_reg;
            2'h2:    prim = s2_reg[4];
            default: prim = tx_reg;
        endcase
    end
    logic eff_perm;
    always_comb begin
        if (!cfg_reg.ilk_bound) begin
            eff_perm = prim;
        end else if (cfg_reg.ilk_and) begin
            eff_perm = prim & s2_reg[5];
        end else begin
            eff_perm = prim | s2_reg[5];
        end
    end

    // Registered permissive and transaction outputs
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            PERMISSIVE_OUT  <= 1'b0;
            TRANSACTION_OUT <= 1'b0;
        end else begin
            PERMISSIVE_OUT  <= eff_perm;
            TRANSACTION_OUT <= eff_perm &&
                ((cfg_reg.perm_src != 2'h0) || mode != aipc_pkg::OM_SELF);
        end
    end
endmodule : aipc_core
`default_nettype wire

//--- bench/aipc_meter.sv
// Flow meter model that drives the pacing pulse pins
`timescale 1ns/1ps
`default_nettype none
module aipc_meter (
    input  wire logic clk_in,
    output logic      pulse_out,
    output logic      pulse_b_out
);
    initial pulse_out = 1'b0;
    // Second channel trails the first by one cycle
    always @(posedge clk_in) pulse_b_out <= pulse_out;
    // Pulses four cycles high, four low, slow enough for the synchroniser
    task burst(input int n);
        repeat (n) begin
            @(posedge clk_in);
            pulse_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            pulse_out <= 1'b0;
            repeat (3) @(posedge clk_in);
        end
    endtask : burst
endmodule : aipc_meter
`default_nettype wire

//--- bench/aipc_core_chk.sv
// Port checks for the injection pacing core
`timescale 1ns/1ps
`default_nettype none
`include "aipc_params.svh"
module aipc_core_chk (
    input wire logic        CLOCK_IN,
    input wire logic        RESETN_IN,
    input wire logic        HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0]  HTRANS_IN,
    input wire logic        HWRITE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic        HREADY_IN,
    input wire logic        HREADYOUT_OUT,
    input wire logic        HRESP_OUT,
    input wire logic        DIGITAL_INPUT_SOURCE_IN,
    input wire logic        PERMISSIVE_IN,
    input wire logic        INTERLOCK_IN,
    input wire logic        SOLENOID_OUT,
    input wire logic        TRANSACTION_OUT,
    input wire logic        PERMISSIVE_OUT,
    input wire logic [1:0]  PULSE_INPUTS_USED_OUT
);
    logic [11:0] cfg_reg; // Shadow of the mode word
    logic        wr_reg;  // Mode write in its data phase
    // Shadow follows bus writes to the mode word
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            wr_reg  <= 1'b0;
            cfg_reg <= 12'h000;
        end else begin
            wr_reg <= HSEL_IN && HTRANS_IN[1] && HREADY_IN && HWRITE_IN
                && HADDR_IN[11:0] == `AIPC_OFF_MODE;
            if (wr_reg) cfg_reg <= HWDATA_IN[11:0];
        end
    end
    wire sl_dig = cfg_reg[11:10] == 2'h1 && cfg_reg[6:4] == 3'h3;
    wire pm_dig = cfg_reg[3:2] == 2'h2; // Digital permissive
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (!RESETN_IN);
    logic [31:0] oc_reg; // Open cycles so far
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) oc_reg <= 32'h0;
        else oc_reg <= SOLENOID_OUT ? oc_reg + 32'h1 : 32'h0;
    end
    // Open one full dose
    sequence s_full_dose;
        oc_reg == `AIPC_RST_INJVOL;
    endsequence
    a_bus_okay: assert property (HREADYOUT_OUT && !HRESP_OUT)
        else $error("bus answer not okay");
    a_used_count: assert property (PULSE_INPUTS_USED_OUT ==
        ((cfg_reg[11:7] == 5'h01) ? 2'h2 : 2'h1))
        else $error("pulse input count wrong");
    a_slave_open: assert property ($rose(DIGITAL_INPUT_SOURCE_IN)
        && sl_dig |-> ##[1:4] SOLENOID_OUT) else $error("slave not open");
    a_slave_close: assert property ($fell(DIGITAL_INPUT_SOURCE_IN)
        && sl_dig |-> ##[1:4] !SOLENOID_OUT) else $error("slave not shut");
    a_perm_rise: assert property ($rose(PERMISSIVE_IN) && pm_dig
        && !cfg_reg[1] |-> ##[1:4] PERMISSIVE_OUT) else $error("no permit");
    a_perm_fall: assert property ($fell(PERMISSIVE_IN) && pm_dig
        && !cfg_reg[1] |-> ##[1:4] !PERMISSIVE_OUT) else $error("permit held");
    a_ilk_and: assert property ((pm_dig && cfg_reg[1:0] == 2'h3
        && !INTERLOCK_IN) [*5] |-> !PERMISSIVE_OUT) else $error("and broken");
    a_tx_start: assert property ($rose(PERMISSIVE_OUT) && pm_dig
        |-> ##[0:2] TRANSACTION_OUT) else $error("transaction late");
    a_inject_len: assert property ($fell(SOLENOID_OUT) && pm_dig
        && PERMISSIVE_OUT && cfg_reg[11:10] != 2'h1 |-> s_full_dose)
        else $error("injection length wrong");
endmodule : aipc_core_chk
bind aipc_core aipc_core_chk chk_u (.CLOCK_IN, .RESETN_IN, .HSEL_IN,
    .HADDR_IN, .HTRANS_IN, .HWRITE_IN, .HWDATA_IN, .HREADY_IN,
    .HREADYOUT_OUT, .HRESP_OUT, .DIGITAL_INPUT_SOURCE_IN, .PERMISSIVE_IN,
    .INTERLOCK_IN, .SOLENOID_OUT, .TRANSACTION_OUT, .PERMISSIVE_OUT,
    .PULSE_INPUTS_USED_OUT);
`default_nettype wire

//--- bench/aipc_core_tb.sv
// Self-checking bench for the injection pacing core
`timescale 1ns/1ps
`default_nettype none
`include "aipc_params.svh"
module aipc_core_tb;
    logic clk = 0, rstn = 0, hsel = 0, hw = 0, rdp = 0;
    logic dig = 0, perm = 0, ilk = 0; // Pins driven by the bench
    logic [1:0]  htr = 2'h0;
    logic [31:0] ha = 32'h0, hwd = 32'h0, mk;
    wire logic [31:0] rdata;
    wire logic [1:0]  used;
    wire logic rdy, resp, sol, tx, pmo, pa, pb;
    logic [31:0] eq[$], mq[$]; // Expected reads and masks
    int n_mismatch = 0, n_compared = 0, cyc = 0, seed = 43, nd;
    logic [7:0] tbl[7] = '{8'h08, 8'h10, 8'h18, 8'h20, 8'h43, 8'h44, 8'h80};
    initial forever #50 clk = ~clk;
    aipc_core dut_u (.CLOCK_IN(clk), .RESETN_IN(rstn), .HSEL_IN(hsel),
        .HADDR_IN(ha), .HTRANS_IN(htr), .HWRITE_IN(hw), .HSIZE_IN(3'h2),
        .HWDATA_IN(hwd), .HREADY_IN(rdy), .HRDATA_OUT(rdata),
        .HREADYOUT_OUT(rdy), .HRESP_OUT(resp), .PULSE_INPUT_SOURCE_IN(pa),
        .PULSE_INPUT_SOURCE_B_IN(pb), .ANALOG_INPUT_SOURCE_IN(1'b0),
        .DIGITAL_INPUT_SOURCE_IN(dig), .PERMISSIVE_IN(perm),
        .INTERLOCK_IN(ilk), .SOLENOID_OUT(sol), .TRANSACTION_OUT(tx),
        .PERMISSIVE_OUT(pmo), .PULSE_INPUTS_USED_OUT(used));
    aipc_meter mtr_u (.clk_in(clk), .pulse_out(pa), .pulse_b_out(pb));
    task chk(input string nm, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task cy(input int n);
        repeat (n) @(posedge clk);
    endtask : cy
    // One single AHB transfer; reads queue their expectation
    task bus(input logic w, input logic [31:0] a, d, m);
        @(posedge clk);
        {hsel, htr, hw, ha} <= {1'b1, 2'h2, w, a};
        @(posedge clk);
        while (!rdy) @(posedge clk);
        {hsel, htr, hwd, rdp} <= {1'b0, 2'h0, d, !w};
        if (!w) eq.push_back(d);
        if (!w) mq.push_back(m);
        @(posedge clk);
        while (!rdy) @(posedge clk);
        rdp <= 1'b0;
    endtask : bus
    task rd(input logic [31:0] a, e);
        bus(1'b0, a, e, 32'hFFFFFFFF);
    endtask : rd
    task wr(input logic [31:0] a, d);
        bus(1'b1, a, d, 32'h0);
    endtask : wr
    task go(input logic [7:0] m, input logic [3:0] p);
        rstn <= 1'b0;
        cy(5);
        rstn <= 1'b1;
        wr(`AIPC_OFF_MODE, {20'h0, m, p});
    endtask : go
    // Read data compared at the edge that ends the data phase
    always @(posedge clk) if (rdp) begin
        mk = mq.pop_front();
        chk("read data", rdata & mk, eq.pop_front() & mk);
    end
    // Hang guard
    always @(posedge clk) if (++cyc == 20000) begin
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        go(8'h00, 4'h0);
        rd(`AIPC_OFF_KFACTOR, `AIPC_RST_KFACTOR);
        rd(`AIPC_OFF_INJVOL, `AIPC_RST_INJVOL);
        rd(32'h100, 32'h0);
        for (int i = 0; i < 7; i++) begin
            go(tbl[i], 4'h0);
            bus(1'b0, `AIPC_OFF_STATUS, i << 7, 32'h380);
            chk("inputs used", used, (i == 0) ? 2 : 1);
        end
        go(8'h08, 4'h8);
        perm <= 1'b1;
        wr(`AIPC_OFF_KFACTOR, 2);
        wr(`AIPC_OFF_VPI, 3);
        mtr_u.burst(14);
        cy(10);
        rd(`AIPC_OFF_INJCNT, 2);
        mtr_u.burst(4);
        cy(10);
        rd(`AIPC_OFF_INJCNT, 3);
        go(8'h18, 4'h8);
        nd = 1 + ($random(seed) & 3);
        repeat (nd) begin
            dig <= 1'b1;
            cy(20);
            dig <= 1'b0;
            cy(20);
        end
        rd(`AIPC_OFF_INJCNT, nd);
        rd(`AIPC_OFF_WILDVOL, nd * `AIPC_RST_VPI);
        go(8'h20, 4'h8);
        repeat (2) begin
            wr(`AIPC_OFF_CMD, 1);
            cy(30);
        end
        rd(`AIPC_OFF_INJCNT, 2);
        go(8'h80, 4'h8);
        wr(`AIPC_OFF_SELFPER, 50);
        cy(270);
        rd(`AIPC_OFF_INJCNT, 5);
        perm <= 1'b0;
        cy(6);
        chk("transaction", tx, 0);
        $display("test pacing ended");
        go(8'h43, 4'h0);
        dig <= 1'b1;
        cy(8);
        chk("solenoid", sol, 1);
        dig <= 1'b0;
        cy(8);
        chk("solenoid", sol, 0);
        go(8'h44, 4'h0);
        wr(`AIPC_OFF_CMD, 2);
        cy(20);
        chk("solenoid", sol, 1);
        wr(`AIPC_OFF_CMD, 4);
        cy(5);
        chk("solenoid", sol, 0);
        $display("test slave ended");
        go(8'h20, 4'h4);
        wr(`AIPC_OFF_CMD, 8);
        cy(5);
        chk("transaction", tx, 1);
        wr(`AIPC_OFF_CMD, 16);
        cy(5);
        chk("transaction", tx, 0);
        go(8'h18, 4'h0);
        wr(`AIPC_OFF_ENDTIME, 30);
        dig <= 1'b1;
        cy(8);
        chk("transaction", tx, 1);
        dig <= 1'b0;
        cy(45);
        chk("transaction", tx, 0);
        perm <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            go(8'h20, 4'hA + k);
            cy(8);
            chk("permissive", pmo, k == 0);
        end
        $display("test permissive ended");
        report_and_stop;
    end
endmodule : aipc_core_tb
`default_nettype wire
